// [dv/acc_analog_model.sv]
// behavioural analog front end: pin and reference levels into two comparators
`timescale 1ns/1ps
module acc_analog_model (
  input wire logic clk,
  input wire logic [1:0] comparator_enable,
  input wire logic [3:0] inverting_input_select,
  input wire logic [1:0] noninverting_source_select,
  input wire logic [3:0] ref_level,
  input wire logic [7:0] plus_level,
  input wire logic [15:0] minus_level,
  output logic [1:0] raw_result
);
  logic [1:0] noise = 2'h1;
  always @(posedge clk) begin
    noise <= ~noise;
  end
  // an unpowered comparator gives no valid answer, so it chatters
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!comparator_enable[i]) begin
        raw_result[i] = noise[i];
      end else begin
        raw_result[i] = (noninverting_source_select[i] ? ref_level : plus_level[i*4+:4])
          > minus_level[inverting_input_select[i*2+:2]*4+:4];
      end
    end
  end
endmodule : acc_analog_model

// [dv/test_acc_top.sv]
// self-checking bench for the analog comparator control block
`timescale 1ns/1ps
module test_acc_top;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, raw_result, comparator_enable;
  logic [1:0] noninverting_source_select, speed_power_select, pin_out, pin_oe;
  logic [3:0] inverting_input_select;
  logic [31:0] s_axi_rdata;
  logic [3:0] ref_level = 4'hf;
  logic [7:0] plus_level = 8'h77;
  logic [15:0] minus_level = 16'hc2c2;
  int n_errors = 0;
  int checked = 0;
  always #4 clk = ~clk;
  acc_top u_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .raw_result, .comparator_enable, .inverting_input_select,
    .noninverting_source_select, .speed_power_select, .pin_in(2'h0), .pin_out, .pin_oe,
    .irq);
  acc_analog_model u_analog (.clk, .comparator_enable, .inverting_input_select,
    .noninverting_source_select, .ref_level, .plus_level, .minus_level, .raw_result);
  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // ready sampled at the falling edge, so the decision matches what the rising edge sees
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    logic ta;
    logic tw;
    pa = 1'h1;
    pw = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : rd
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", acc_pkg::RESP_OKAY, r);
  endtask : w
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, exp, d);
    chk("rresp", acc_pkg::RESP_OKAY, r);
  endtask : rc
  // long enough for two sync stages, the next q1 and the flag edge
  task automatic settle();
    repeat (12) @(posedge clk);
  endtask : settle
  task automatic lv(input logic [3:0] v);
    plus_level[3:0] <= v;
    settle();
  endtask : lv
  task automatic ev(input logic f, input logic i);
    rc("flag", acc_pkg::OFF_FLAG, {31'h0, f});
    chk("irq", {31'h0, i}, {31'h0, irq});
  endtask : ev
  task automatic t_reset();
    chk("en", 2'h0, comparator_enable);
    chk("speed", 2'h3, speed_power_select);
    chk("pin_oe", 2'h0, pin_oe);
    rc("ctrl0", acc_pkg::OFF_CTRL0, 8'h08);
    rc("ctrl1", acc_pkg::OFF_CTRL1, 8'h08);
    rc("shared", acc_pkg::OFF_SHARED, 8'h00);
    ev(1'h0, 1'h0);
  endtask : t_reset
  task automatic t_select();
    logic [7:0] v;
    for (int s = 0; s < 4; s++) begin
      v = 8'h80 | 8'(s);
      w(acc_pkg::OFF_CTRL0, v);
      w(acc_pkg::OFF_CTRL1, v);
      settle();
      v[6] = plus_level[3:0] > minus_level[s*4+:4];
      chk("sel", {s[1:0], s[1:0]}, inverting_input_select);
      chk("en", 2'h3, comparator_enable);
      chk("speed", 2'h0, speed_power_select);
      rc("ctrl0", acc_pkg::OFF_CTRL0, v);
      rc("ctrl1", acc_pkg::OFF_CTRL1, v);
      rc("shared", acc_pkg::OFF_SHARED, {v[6], v[6]});
    end
    w(acc_pkg::OFF_CTRL0, 8'h85);
    settle();
    chk("nsrc", 2'h1, noninverting_source_select);
    rc("ctrl0", acc_pkg::OFF_CTRL0, 8'hc5);
  endtask : t_select
  task automatic t_invert();
    w(acc_pkg::OFF_CTRL0, 8'h90);
    w(acc_pkg::OFF_CTRL1, 8'h80);
    settle();
    rc("ctrl0", acc_pkg::OFF_CTRL0, 8'h90);
    rc("shared", acc_pkg::OFF_SHARED, 8'h02);
    w(acc_pkg::OFF_CTRL0, 8'h10);
    w(acc_pkg::OFF_CTRL1, 8'h00);
    settle();
    rc("ctrl0", acc_pkg::OFF_CTRL0, 8'h50);
    rc("shared", acc_pkg::OFF_SHARED, 8'h01);
  endtask : t_invert
  task automatic t_pin();
    w(acc_pkg::OFF_PINCTL, 8'h0c);
    w(acc_pkg::OFF_CTRL0, 8'h00);
    settle();
    chk("pin_oe", 2'h3, pin_oe);
    chk("pin latch", 2'h3, pin_out);
    w(acc_pkg::OFF_CTRL0, 8'h20);
    settle();
    chk("pin off", 2'h2, pin_out);
    w(acc_pkg::OFF_CTRL0, 8'ha0);
    settle();
    chk("pin on", 2'h3, pin_out);
    w(acc_pkg::OFF_CTRL0, 8'hb0);
    settle();
    chk("pin inv", 2'h2, pin_out);
    w(acc_pkg::OFF_PINCTL, 8'h0f);
    chk("pin_oe", 2'h0, pin_oe);
  endtask : t_pin
  task automatic t_event();
    w(acc_pkg::OFF_CTRL0, 8'ha0);
    settle();
    rc("ctrl0", acc_pkg::OFF_CTRL0, 8'he0);
    w(acc_pkg::OFF_FLAG, 8'h00);
    w(acc_pkg::OFF_EVEN, 8'h01);
    w(acc_pkg::OFF_IRQCTL, 8'h03);
    ev(1'h0, 1'h0);
    lv(4'h1);
    ev(1'h1, 1'h1);
    w(acc_pkg::OFF_FLAG, 8'h00);
    settle();
    ev(1'h0, 1'h0);
    lv(4'h7);
    ev(1'h0, 1'h0);
    lv(4'h1);
    ev(1'h1, 1'h1);
    w(acc_pkg::OFF_FLAG, 8'h00);
    rc("ctrl0", acc_pkg::OFF_CTRL0, 8'ha0);
    lv(4'h7);
    ev(1'h1, 1'h1);
    w(acc_pkg::OFF_FLAG, 8'h00);
    lv(4'h1);
    w(acc_pkg::OFF_FLAG, 8'h00);
    w(acc_pkg::OFF_CTRL0, 8'ha0);
    lv(4'h7);
    ev(1'h1, 1'h1);
    w(acc_pkg::OFF_IRQCTL, 8'h01);
    ev(1'h1, 1'h0);
    w(acc_pkg::OFF_IRQCTL, 8'h02);
    ev(1'h1, 1'h0);
    w(acc_pkg::OFF_IRQCTL, 8'h03);
    w(acc_pkg::OFF_EVEN, 8'h00);
    ev(1'h1, 1'h0);
    w(acc_pkg::OFF_FLAG, 8'h00);
    w(acc_pkg::OFF_EVEN, 8'h01);
    ev(1'h0, 1'h0);
    w(acc_pkg::OFF_FLAG, 8'h01);
    ev(1'h1, 1'h1);
  endtask : t_event
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h40, 8'hff, r);
    chk("bresp bad", acc_pkg::RESP_SLVERR, r);
    rd(8'h40, d, r);
    chk("rresp bad", acc_pkg::RESP_SLVERR, r);
    chk("rdata bad", 32'h0000_0000, d);
    w(acc_pkg::OFF_SHARED, 8'hff);
    w(acc_pkg::OFF_CTRL1, 8'h40);
    rc("ctrl1 ro", acc_pkg::OFF_CTRL1, 8'h00);
    // low byte strobe off: the write is answered but changes nothing
    s_axi_wstrb <= 4'he;
    w(acc_pkg::OFF_CTRL1, 8'h80);
    s_axi_wstrb <= 4'hf;
    rc("ctrl1 strb", acc_pkg::OFF_CTRL1, 8'h00);
    rc("shared ro", acc_pkg::OFF_SHARED, 8'h01);
  endtask : t_bus
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    t_reset();
    t_select();
    t_invert();
    t_pin();
    t_event();
    t_bus();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule : test_acc_top

// [hdl/acc_channel.sv]
// one comparator: result latch, mismatch latch pair and event edge
`timescale 1ns/1ps
module acc_channel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raw_async,
  input wire logic enable,
  input wire logic invert,
  input wire logic q1,
  input wire logic capture,
  output logic result,
  output logic live_result,
  output logic mismatch,
  output logic event_pulse
);
  logic raw_sync;
  logic read_latch;
  logic mismatch_d;

  acc_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(raw_async),
    .sync_out(raw_sync)
  );

  // disabled comparator reports the polarity bit so the latches can be preset
  assign live_result = enable ? (raw_sync ^ invert) : invert;
  assign mismatch = read_latch ^ result;
  assign event_pulse = mismatch & ~mismatch_d;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= 1'b0;
      read_latch <= 1'b0;
      mismatch_d <= 1'b0;
    end else begin
      if (q1) begin
        result <= live_result;
      end
      // a read in a q1 cycle takes the old level: the change still shows as a mismatch
      if (capture) begin
        read_latch <= result;
      end
      mismatch_d <= mismatch;
    end
  end
endmodule : acc_channel

// [hdl/acc_pkg.sv]
// constants for the analog comparator control block
package acc_pkg;
  localparam int NUM_CMP = 2;
  localparam int NUM_PHASES = 4;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_SHARED = 8'h08;
  localparam logic [7:0] OFF_FLAG = 8'h0C;
  localparam logic [7:0] OFF_EVEN = 8'h10;
  localparam logic [7:0] OFF_IRQCTL = 8'h14;
  localparam logic [7:0] OFF_PINCTL = 8'h18;
  // comparator control register fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_RESULT = 6;
  localparam int BIT_OE = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_SPEED = 3;
  localparam int BIT_NSRC = 2;
  localparam int SEL_LSB = 0;
  localparam int SEL_WIDTH = 2;
  // irq control register fields
  localparam int BIT_PERIPH_IE = 0;
  localparam int BIT_GLOBAL_IE = 1;
  // pin control register: direction bits low, port data latch above
  localparam int DIR_LSB = 0;
  localparam int LATCH_LSB = 2;
  // reset values and bus response codes
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [1:0] FLAG_RESET = 2'h0;
  localparam logic [1:0] EVEN_RESET = 2'h0;
  localparam logic [1:0] IRQCTL_RESET = 2'h0;
  localparam logic [3:0] PINCTL_RESET = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : acc_pkg

// [hdl/acc_sync.sv]
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module acc_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : acc_sync

// [hdl/acc_top.sv]
// analog comparator control block with an axi4-lite register slave
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module acc_top #(
  parameter int N = acc_pkg::NUM_CMP
) (
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog side
  input wire logic [N-1:0] raw_result,
  output logic [N-1:0] comparator_enable,
  output logic [N*2-1:0] inverting_input_select,
  output logic [N-1:0] noninverting_source_select,
  output logic [N-1:0] speed_power_select,
  // comparator output pins
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe,
  // processor interrupt
  output logic irq
);
  typedef logic [7:0] acc_byte_type;

  // register state
  acc_byte_type cfg [N];
  logic [N-1:0] comparator_event_flag;
  logic [N-1:0] comparator_event_enable;
  logic peripheral_irq_enable;
  logic global_irq_enable;
  logic [N-1:0] pin_direction_bit;
  logic [N-1:0] port_latch;

  // bus state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] phase;

  // channel signals
  logic [N-1:0] result;
  logic [N-1:0] live_result;
  logic [N-1:0] mismatch;
  logic [N-1:0] event_pulse;
  logic [N-1:0] capture;

  // decode shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == acc_pkg::OFF_CTRL0) || (addr == acc_pkg::OFF_CTRL1)
      || (addr == acc_pkg::OFF_SHARED) || (addr == acc_pkg::OFF_FLAG)
      || (addr == acc_pkg::OFF_EVEN) || (addr == acc_pkg::OFF_IRQCTL)
      || (addr == acc_pkg::OFF_PINCTL);
  endfunction : is_mapped

  function automatic logic [1:0] ctrl_hit(input logic [7:0] addr);
    ctrl_hit = {addr == acc_pkg::OFF_CTRL1, addr == acc_pkg::OFF_CTRL0};
  endfunction : ctrl_hit

  // bus handshakes
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane0 = do_write && w_strb[0];
  wire [1:0] wr_ctrl = ctrl_hit(aw_addr) & {2{wr_lane0}};
  wire [1:0] rd_ctrl = ctrl_hit(s_axi_araddr) & {2{ar_take}};
  wire wr_flag = wr_lane0 && (aw_addr == acc_pkg::OFF_FLAG);
  wire wr_even = wr_lane0 && (aw_addr == acc_pkg::OFF_EVEN);
  wire wr_irqctl = wr_lane0 && (aw_addr == acc_pkg::OFF_IRQCTL);
  wire wr_pinctl = wr_lane0 && (aw_addr == acc_pkg::OFF_PINCTL);
  wire q1 = (phase == acc_pkg::PHASE_Q1);
  wire phase_last = (phase == 2'(acc_pkg::NUM_PHASES - 1));

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // every control register write with byte lane 0 strobed starts with a read of it, so both clear the mismatch
  assign capture = rd_ctrl | wr_ctrl;

  // the flag register: events win over a software clear in the same cycle
  wire [N-1:0] next_flag = (wr_flag ? w_data[N-1:0] : comparator_event_flag)
    | event_pulse;

  assign irq = |(comparator_event_flag & comparator_event_enable)
    && peripheral_irq_enable && global_irq_enable;

  // read data mux
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (s_axi_araddr == acc_pkg::OFF_CTRL0) begin
      next_rdata[7:0] = cfg[0];
      next_rdata[acc_pkg::BIT_RESULT] = result[0];
    end else if (s_axi_araddr == acc_pkg::OFF_CTRL1) begin
      next_rdata[7:0] = cfg[1];
      next_rdata[acc_pkg::BIT_RESULT] = result[1];
    end else if (s_axi_araddr == acc_pkg::OFF_SHARED) begin
      next_rdata[N-1:0] = result;
    end else if (s_axi_araddr == acc_pkg::OFF_FLAG) begin
      next_rdata[N-1:0] = comparator_event_flag;
    end else if (s_axi_araddr == acc_pkg::OFF_EVEN) begin
      next_rdata[N-1:0] = comparator_event_enable;
    end else if (s_axi_araddr == acc_pkg::OFF_IRQCTL) begin
      next_rdata[acc_pkg::BIT_PERIPH_IE] = peripheral_irq_enable;
      next_rdata[acc_pkg::BIT_GLOBAL_IE] = global_irq_enable;
    end else if (s_axi_araddr == acc_pkg::OFF_PINCTL) begin
      next_rdata[acc_pkg::DIR_LSB +: N] = pin_direction_bit;
      next_rdata[acc_pkg::LATCH_LSB +: N] = port_latch;
    end
  end

  // instruction cycle phase counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= acc_pkg::PHASE_Q1;
    end else if (phase_last) begin
      phase <= acc_pkg::PHASE_Q1;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // write address and data are taken in either order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= acc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= acc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // shared registers; the result bit is read-only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      comparator_event_flag <= acc_pkg::FLAG_RESET;
      comparator_event_enable <= acc_pkg::EVEN_RESET;
      peripheral_irq_enable <= acc_pkg::IRQCTL_RESET[acc_pkg::BIT_PERIPH_IE];
      global_irq_enable <= acc_pkg::IRQCTL_RESET[acc_pkg::BIT_GLOBAL_IE];
      pin_direction_bit <= acc_pkg::PINCTL_RESET[acc_pkg::DIR_LSB +: 2];
      port_latch <= acc_pkg::PINCTL_RESET[acc_pkg::LATCH_LSB +: 2];
    end else begin
      comparator_event_flag <= next_flag;
      if (wr_even) begin
        comparator_event_enable <= w_data[N-1:0];
      end
      if (wr_irqctl) begin
        peripheral_irq_enable <= w_data[acc_pkg::BIT_PERIPH_IE];
        global_irq_enable <= w_data[acc_pkg::BIT_GLOBAL_IE];
      end
      if (wr_pinctl) begin
        pin_direction_bit <= w_data[acc_pkg::DIR_LSB +: N];
        port_latch <= w_data[acc_pkg::LATCH_LSB +: N];
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_cmp
      // new config lands in the same edge as the latch capture, after it
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg[i] <= acc_pkg::CTRL_RESET;
        end else if (wr_ctrl[i]) begin
          cfg[i] <= w_data[7:0] & ~(8'h01 << acc_pkg::BIT_RESULT);
        end
      end

      // event path ignores the pin output enable entirely
      acc_channel u_channel (
        .clk(clk),
        .rst_b(rst_b),
        .raw_async(raw_result[i]),
        .enable(cfg[i][acc_pkg::BIT_ENABLE]),
        .invert(cfg[i][acc_pkg::BIT_INVERT]),
        .q1(q1),
        .capture(capture[i]),
        .result(result[i]),
        .live_result(live_result[i]),
        .mismatch(mismatch[i]),
        .event_pulse(event_pulse[i])
      );

      assign comparator_enable[i] = cfg[i][acc_pkg::BIT_ENABLE];
      assign inverting_input_select[i*2 +: 2] =
        cfg[i][acc_pkg::SEL_LSB +: acc_pkg::SEL_WIDTH];
      assign noninverting_source_select[i] = cfg[i][acc_pkg::BIT_NSRC];
      assign speed_power_select[i] = cfg[i][acc_pkg::BIT_SPEED];
      // pin path bypasses the instruction-cycle latch to keep its delay short
      assign pin_out[i] = cfg[i][acc_pkg::BIT_OE]
        ? (cfg[i][acc_pkg::BIT_ENABLE] & live_result[i]) : port_latch[i];
      assign pin_oe[i] = ~pin_direction_bit[i];

      a_flag_on_event: assert property (@(posedge clk) disable iff (!rst_b)
        event_pulse[i] |=> comparator_event_flag[i])
        else $error("event did not set flag");
      a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        comparator_event_flag[i] && !wr_flag |=> comparator_event_flag[i])
        else $error("flag cleared without software write");
      a_read_clears_mismatch: assert property (@(posedge clk) disable iff (!rst_b)
        capture[i] && !q1 |=> !mismatch[i])
        else $error("read did not clear mismatch");
      a_result_q1_only: assert property (@(posedge clk) disable iff (!rst_b)
        !q1 |=> $stable(result[i]))
        else $error("result changed outside q1");
      a_disabled_level: assert property (@(posedge clk) disable iff (!rst_b)
        q1 && !cfg[i][acc_pkg::BIT_ENABLE] |=> result[i] == $past(cfg[i][acc_pkg::BIT_INVERT]))
        else $error("disabled result not set by invert bit");
      a_event_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
        event_pulse[i] |=> !event_pulse[i])
        else $error("event held longer than one cycle");
      a_pin_gate: assert property (@(posedge clk) disable iff (!rst_b)
        cfg[i][acc_pkg::BIT_OE] && !cfg[i][acc_pkg::BIT_ENABLE] |-> !pin_out[i])
        else $error("disabled comparator drove its pin high");
      a_mismatch_edge: assert property (@(posedge clk) disable iff (!rst_b)
        q1 && !capture[i] && (live_result[i] != result[i]) && !mismatch[i]
        |=> mismatch[i] ##1 !event_pulse[i])
        else $error("result change gave no single mismatch edge");
      // mismatch may only move when a latch is loaded
      a_mismatch_steady: assert property (@(posedge clk) disable iff (!rst_b)
        !q1 && !capture[i] |=> $stable(mismatch[i]))
        else $error("mismatch changed with no latch update");
      a_write_clears: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ctrl[i] && !q1 |=> !mismatch[i])
        else $error("control write did not clear mismatch");
      a_event_needs: assert property (@(posedge clk) disable iff (!rst_b)
        event_pulse[i] |-> mismatch[i])
        else $error("event without mismatch");
      a_flag_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_flag |=> comparator_event_flag[i] == ($past(w_data[i]) | $past(event_pulse[i])))
        else $error("flag write not applied");
      a_cfg_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ctrl[i] |=> cfg[i][acc_pkg::BIT_ENABLE] == $past(w_data[acc_pkg::BIT_ENABLE])
          && cfg[i][acc_pkg::BIT_INVERT] == $past(w_data[acc_pkg::BIT_INVERT]))
        else $error("control write did not apply enable and polarity");
      a_pin_follows: assert property (@(posedge clk) disable iff (!rst_b)
        cfg[i][acc_pkg::BIT_OE] && cfg[i][acc_pkg::BIT_ENABLE] |-> pin_out[i] == live_result[i])
        else $error("pin does not follow comparator");
      a_pin_latch: assert property (@(posedge clk) disable iff (!rst_b)
        !cfg[i][acc_pkg::BIT_OE] |-> pin_out[i] == port_latch[i])
        else $error("pin does not follow port latch");
    end
  endgenerate

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
    irq |-> peripheral_irq_enable && global_irq_enable && |comparator_event_enable)
    else $error("interrupt raised while not enabled");
  a_write_answer: assert property (@(posedge clk) disable iff (!rst_b)
    do_write |=> s_axi_bvalid && !aw_held && !w_held)
    else $error("write not answered one cycle after execution");
  a_mirror_read: assert property (@(posedge clk) disable iff (!rst_b)
    ar_take && s_axi_araddr == acc_pkg::OFF_SHARED |=> s_axi_rvalid
      && s_axi_rdata[N-1:0] == $past(result))
    else $error("shared register did not mirror results");
  a_speed_reset: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == acc_pkg::OFF_CTRL0
      && $past(cfg[0]) == acc_pkg::CTRL_RESET |-> s_axi_rdata[acc_pkg::BIT_SPEED])
    else $error("speed bit not high at reset value");
  a_irq_on_flag: assert property (@(posedge clk) disable iff (!rst_b)
    |(comparator_event_flag & comparator_event_enable) && peripheral_irq_enable
      && global_irq_enable |-> irq)
    else $error("enabled flag raised no interrupt");
  a_read_answer: assert property (@(posedge clk) disable iff (!rst_b)
    ar_take |=> s_axi_rvalid)
    else $error("read not answered one cycle after address");
  a_phase_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    phase_last |=> q1)
    else $error("instruction cycle did not wrap to q1");
  a_bresp_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
    do_write && !is_mapped(aw_addr) |=> s_axi_bresp == acc_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule : acc_top
